// ==== hdl/adl_defines.svh ====
// register indices, field positions, reset values and constants of the control bank
`ifndef ADL_DEFINES_SVH
`define ADL_DEFINES_SVH

// register indices; the byte address on the bus is four times the index
`define ADL_IDX_DITHER 12'h09d
`define ADL_IDX_LSB_CTRL 12'h160
`define ADL_IDX_LINK_EN 12'h200
`define ADL_IDX_MODE 12'h201
`define ADL_IDX_KM1 12'h202
`define ADL_IDX_AUX 12'h210
`define ADL_IDX_STATUS 12'h211

// reset values
`define ADL_RST_DITHER 8'h00
`define ADL_RST_LSB_CTRL 8'h00
`define ADL_RST_LINK_EN 8'h01
`define ADL_RST_MODE 8'h00
`define ADL_RST_KM1 8'h1f
`define ADL_RST_AUX 8'h00

// field positions
`define ADL_BIT_DITH_EN 0
`define ADL_BIT_DITH_AMP 1
`define ADL_BIT_DITH_ERR 2
`define ADL_BIT_TS_EN 0
`define ADL_BIT_LINK_EN 0
`define ADL_MODE_MSB 5
`define ADL_BIT_AUX_CAL 0
`define ADL_BIT_AUX_TSRX 1

// frames per multiframe scale for 64b/66b modes
`define ADL_K_64B_SCALE 16'h0100

`endif

// ==== hdl/adl_pkg.sv ====
// types shared by the control bank and its sample path
package adl_pkg;

   // dither steering handed to the converter core
   typedef struct packed {
      logic rounding_select;
      logic amplitude_select;
      logic enable;
   } adl_dither_t;

   // link subsystem power and reset controls
   typedef struct packed {
      logic hold_reset;
      logic serdes_power_down;
      logic clock_enable;
   } adl_link_ctrl_t;

   // bus slave states
   typedef enum logic {
      bus_idle,
      bus_read
   } adl_bus_state_t;

endpackage

// ==== hdl/adl_sample_path.sv ====
// sample path: aligns the timestamp with the samples and packs the link field
`timescale 1ns/100ps
`default_nettype none
module adl_sample_path #(
   parameter int ADC_W = 9,
   parameter int LINK_W = 12,
   parameter int LAT = 4
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // controls
   input wire logic hold_reset,
   input wire logic insert_enable,
   input wire logic receiver_enable,
   // converter side
   input wire logic [ADC_W-1:0] adc_sample,
   input wire logic timestamp_in,
   // link side
   output logic [LINK_W-1:0] link_sample
);
   import adl_pkg::*;

   logic [ADC_W-1:0] data_pipe [LAT];
   logic ts_pipe [LAT];
   logic [LINK_W-1:0] next_link_sample;

   // equal-depth delay lines so the mark lands on the sample it belongs to
   genvar gi;
   generate
      for (gi = 0; gi < LAT; gi++) begin : g_stage
         logic [ADC_W-1:0] data_src;
         logic ts_src;
         // the first stage feeds from the pins, so no stage ever indexes below zero
         if (gi == 0) begin : g_first
            assign data_src = adc_sample;
            assign ts_src = timestamp_in & receiver_enable;
         end else begin : g_next
            assign data_src = data_pipe[gi-1];
            assign ts_src = ts_pipe[gi-1];
         end
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               data_pipe[gi] <= '0;
               ts_pipe[gi] <= 1'b0;
            end else if (hold_reset) begin
               data_pipe[gi] <= '0;
               ts_pipe[gi] <= 1'b0;
            end else begin
               data_pipe[gi] <= data_src;
               ts_pipe[gi] <= ts_src;
            end
         end
      end
   endgenerate

   // pack: converter bits at the top, the mark in the lowest link bit
   generate
      if (LINK_W > ADC_W) begin : g_wide
         always_comb begin
            next_link_sample = '0;
            next_link_sample[LINK_W-1 -: ADC_W] = data_pipe[LAT-1];
            next_link_sample[0] = insert_enable & ts_pipe[LAT-1];
         end
      end else begin : g_narrow
         // no spare bit: the mark has to take the lowest converter bit kept in the link field
         always_comb begin
            next_link_sample = data_pipe[LAT-1][ADC_W-1 -: LINK_W];
            if (insert_enable) begin
               next_link_sample[0] = ts_pipe[LAT-1];
            end
         end
      end
   endgenerate

   // output flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link_sample <= '0;
      end else if (hold_reset) begin
         link_sample <= '0;
      end else begin
         link_sample <= next_link_sample;
      end
   end

endmodule
`default_nettype wire

// ==== hdl/adl_link_regs.sv ====
// dither and serial link control bank with an ahb-lite slave
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "adl_defines.svh"
// Operation
// - dither control bit 0 turns dither injection and subtraction on or off.
// - dither control bit 1 picks small dither when zero, large when one.
// - dither control bit 2 sends rounding error to noise or to offset and spurs.
// - timestamp enable bit 0 puts the timestamp input in each sample lsb.
// - the timestamp is delayed to match the latency of the sampled inputs.
// - with a wider link field the mark takes its lowest bit only.
// - lane alignment data reports zero control bits per sample, always.
// - link enable bit 0 switches the link subsystem; it resets to one.
// - while link enable is zero: link reset, serializers down, clocks gated.
// - while disabled the multiframe counter stays reset; sysref cannot realign it.
// - mode register bits 5 to 0 pick the output mode; reset zero.
// - register at 0x202 holds frames per multiframe minus one, reset 0x1f.
// - in 64b/66b modes k is 256 times e over f, ignoring the register.
module adl_link_regs #(
   parameter int ADC_W = 9,
   parameter int LINK_W = 12,
   parameter int SAMPLE_LAT = 4,
   parameter int E_W = 3,
   parameter int F_W = 4
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // converter controls
   output adl_pkg::adl_dither_t dither,
   output logic calibration_enable,
   output logic timestamp_receiver_enable,
   // link configuration and mode table answers
   output logic [5:0] serial_output_mode,
   input wire logic mode_uses_64b66b,
   input wire logic [E_W-1:0] mode_e,
   input wire logic [F_W-1:0] mode_f,
   output adl_pkg::adl_link_ctrl_t link_ctrl,
   output logic [10:0] frames_per_multiframe,
   output logic [1:0] ila_control_bits,
   // framing
   input wire logic frame_tick,
   input wire logic sysref_pulse,
   output logic multiframe_boundary,
   // sample path
   input wire logic [ADC_W-1:0] adc_sample,
   input wire logic timestamp_in,
   output logic [LINK_W-1:0] link_sample
);
   import adl_pkg::*;

   // -----------------------------------------------------------------
   // register storage
   // -----------------------------------------------------------------
   logic [7:0] dither_control;
   logic [7:0] sample_lsb_control;
   logic [7:0] serial_link_enable;
   logic [7:0] mode_reg;
   logic [7:0] frames_per_multiframe_minus_one;
   logic [7:0] aux_control;

   // bus tracking
   adl_bus_state_t state;
   logic wr_pend;
   logic [11:0] wr_idx;
   logic wr_ok;
   logic [11:0] rd_idx;
   logic rd_ok;
   logic take;
   logic addr_ok;
   logic [31:0] next_hrdata;

   // frame counting and derived k
   logic [10:0] mf_count;
   logic [10:0] next_k;
   logic [15:0] k_wide;
   logic [15:0] f_div;
   logic link_on;

   // -----------------------------------------------------------------
   // address phase
   // -----------------------------------------------------------------
   // only aligned words inside the small index window decode
   assign take = hsel & htrans[1] & hready;
   assign addr_ok = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'b00);
   assign link_on = serial_link_enable[`ADL_BIT_LINK_EN];

   // writes complete with no wait; the value lands at the data phase edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx <= 12'h000;
         wr_ok <= 1'b0;
      end else begin
         wr_pend <= take & hwrite;
         wr_idx <= haddr[13:2];
         wr_ok <= addr_ok;
      end
   end

   // reads take one wait state so a read right after a write sees the new value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= bus_idle;
         hreadyout <= 1'b1;
         rd_idx <= 12'h000;
         rd_ok <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         case (state)
            bus_idle: begin
               if (take && !hwrite) begin
                  state <= bus_read;
                  hreadyout <= 1'b0;
                  rd_idx <= haddr[13:2];
                  rd_ok <= addr_ok;
               end
            end
            bus_read: begin
               state <= bus_idle;
               hreadyout <= 1'b1;
               hrdata <= next_hrdata;
            end
            default: begin
               state <= bus_idle;
               hreadyout <= 1'b1;
            end
         endcase
      end
   end

   // the slave never errors; unmapped reads return zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   always_comb begin
      next_hrdata = 32'h00000000;
      if (!rd_ok) begin
         next_hrdata = 32'h00000000;
      end else if (rd_idx == `ADL_IDX_DITHER) begin
         next_hrdata[7:0] = dither_control;
      end else if (rd_idx == `ADL_IDX_LSB_CTRL) begin
         next_hrdata[7:0] = sample_lsb_control;
      end else if (rd_idx == `ADL_IDX_LINK_EN) begin
         next_hrdata[7:0] = serial_link_enable;
      end else if (rd_idx == `ADL_IDX_MODE) begin
         next_hrdata[7:0] = mode_reg;
      end else if (rd_idx == `ADL_IDX_KM1) begin
         next_hrdata[7:0] = frames_per_multiframe_minus_one;
      end else if (rd_idx == `ADL_IDX_AUX) begin
         next_hrdata[7:0] = aux_control;
      end else if (rd_idx == `ADL_IDX_STATUS) begin
         // live link state, effective k and the frame position
         next_hrdata[0] = ~link_ctrl.hold_reset;
         next_hrdata[1] = mode_uses_64b66b;
         next_hrdata[26:16] = frames_per_multiframe;
         next_hrdata[14:4] = mf_count;
      end
   end

   // -----------------------------------------------------------------
   // register writes
   // -----------------------------------------------------------------
   // reserved bits are stored as written; software keeps them zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dither_control <= `ADL_RST_DITHER;
         sample_lsb_control <= `ADL_RST_LSB_CTRL;
         serial_link_enable <= `ADL_RST_LINK_EN;
         mode_reg <= `ADL_RST_MODE;
         frames_per_multiframe_minus_one <= `ADL_RST_KM1;
         aux_control <= `ADL_RST_AUX;
      end else if (wr_pend && wr_ok) begin
         if (wr_idx == `ADL_IDX_DITHER) begin
            dither_control <= hwdata[7:0];
         end else if (wr_idx == `ADL_IDX_LSB_CTRL) begin
            sample_lsb_control <= hwdata[7:0];
         end else if (wr_idx == `ADL_IDX_LINK_EN) begin
            serial_link_enable <= hwdata[7:0];
         end else if (wr_idx == `ADL_IDX_MODE) begin
            mode_reg <= hwdata[7:0];
         end else if (wr_idx == `ADL_IDX_KM1) begin
            frames_per_multiframe_minus_one <= hwdata[7:0];
         end else if (wr_idx == `ADL_IDX_AUX) begin
            aux_control <= hwdata[7:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // converter and link controls
   // -----------------------------------------------------------------
   // outputs follow the registers one edge later, straight from flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dither <= '0;
         calibration_enable <= 1'b0;
         timestamp_receiver_enable <= 1'b0;
         serial_output_mode <= 6'h00;
      end else begin
         dither.enable <= dither_control[`ADL_BIT_DITH_EN];
         dither.amplitude_select <= dither_control[`ADL_BIT_DITH_AMP];
         dither.rounding_select <= dither_control[`ADL_BIT_DITH_ERR];
         calibration_enable <= aux_control[`ADL_BIT_AUX_CAL];
         timestamp_receiver_enable <= aux_control[`ADL_BIT_AUX_TSRX];
         serial_output_mode <= mode_reg[`ADL_MODE_MSB:0];
      end
   end

   // link held in reset, serializers down and clocks gated while disabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link_ctrl.hold_reset <= 1'b1;
         link_ctrl.serdes_power_down <= 1'b1;
         link_ctrl.clock_enable <= 1'b0;
      end else begin
         link_ctrl.hold_reset <= ~link_on;
         link_ctrl.serdes_power_down <= ~link_on;
         link_ctrl.clock_enable <= link_on;
      end
   end

   // the lane alignment data never advertises the timestamp bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ila_control_bits <= 2'b00;
      end else begin
         ila_control_bits <= 2'b00;
      end
   end

   // -----------------------------------------------------------------
   // effective frames per multiframe
   // -----------------------------------------------------------------
   // a zero f from the mode table is treated as one to keep the divide defined
   assign f_div = (mode_f == '0) ? 16'h0001 : 16'(mode_f);
   assign k_wide = (`ADL_K_64B_SCALE * 16'(mode_e)) / f_div;

   always_comb begin
      if (mode_uses_64b66b) begin
         next_k = k_wide[10:0];
      end else begin
         next_k = 11'(frames_per_multiframe_minus_one) + 11'h001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frames_per_multiframe <= 11'h020;
      end else begin
         frames_per_multiframe <= next_k;
      end
   end

   // -----------------------------------------------------------------
   // multiframe counter
   // -----------------------------------------------------------------
   // sysref only realigns a running link; a disabled link holds it at zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mf_count <= 11'h000;
         multiframe_boundary <= 1'b0;
      end else if (link_ctrl.hold_reset) begin
         mf_count <= 11'h000;
         multiframe_boundary <= 1'b0;
      end else if (sysref_pulse) begin
         mf_count <= 11'h000;
         multiframe_boundary <= 1'b1;
      end else if (frame_tick) begin
         if (mf_count + 11'h001 >= frames_per_multiframe) begin
            mf_count <= 11'h000;
            multiframe_boundary <= 1'b1;
         end else begin
            mf_count <= mf_count + 11'h001;
            multiframe_boundary <= 1'b0;
         end
      end else begin
         multiframe_boundary <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // sample path
   // -----------------------------------------------------------------
   adl_sample_path #(
      .ADC_W(ADC_W),
      .LINK_W(LINK_W),
      .LAT(SAMPLE_LAT)
   ) u_sample_path (
      .hclk(hclk),
      .hresetn(hresetn),
      .hold_reset(link_ctrl.hold_reset),
      .insert_enable(sample_lsb_control[`ADL_BIT_TS_EN]),
      .receiver_enable(timestamp_receiver_enable),
      .adc_sample(adc_sample),
      .timestamp_in(timestamp_in),
      .link_sample(link_sample)
   );

endmodule
`default_nettype wire

// ==== tb/adl_link_monitor.sv ====
// concurrent checks on the ports of the dither and serial link control bank
`timescale 1ns/100ps
`default_nettype none
module adl_link_monitor #(
   parameter int ADC_W = 9,
   parameter int LINK_W = 12,
   parameter int E_W = 3,
   parameter int F_W = 4
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // link and framing
   input wire adl_pkg::adl_link_ctrl_t link_ctrl,
   input wire logic mode_uses_64b66b,
   input wire logic [E_W-1:0] mode_e,
   input wire logic [F_W-1:0] mode_f,
   input wire logic [10:0] frames_per_multiframe,
   input wire logic [1:0] ila_control_bits,
   input wire logic sysref_pulse,
   input wire logic multiframe_boundary,
   // sample path
   input wire logic [ADC_W-1:0] adc_sample,
   input wire logic [LINK_W-1:0] link_sample
);
   import adl_pkg::*;
   // ---------------------------------------------
   // helper
   // ---------------------------------------------
   // cycles out of link reset, saturating so the pipeline is known full
   logic [3:0] up_cnt;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_cnt <= 4'h0;
      end else if (link_ctrl.hold_reset) begin
         up_cnt <= 4'h0;
      end else if (up_cnt != 4'hf) begin
         up_cnt <= up_cnt + 4'h1;
      end
   end
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait state");
   a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_link_trio: assert property (link_ctrl.serdes_power_down == link_ctrl.hold_reset && link_ctrl.clock_enable == !link_ctrl.hold_reset)
      else $error("link controls disagree");
   a_ila_zero: assert property (ila_control_bits == 2'b00)
      else $error("lane alignment reports control bits");
   a_k_wide_mode: assert property ($past(hresetn) && mode_uses_64b66b && $past(mode_uses_64b66b) && $stable(mode_e) && $stable(mode_f) |-> frames_per_multiframe == 11'((256 * int'(mode_e)) / ((mode_f == '0) ? 1 : int'(mode_f))))
      else $error("frames per multiframe wrong in wide mode");
   a_sysref_mark: assert property (sysref_pulse && up_cnt > 4'h2 && !link_ctrl.hold_reset |=> multiframe_boundary)
      else $error("sysref did not mark a boundary");
   a_quiet_off: assert property (link_ctrl.hold_reset && $past(link_ctrl.hold_reset) |-> !multiframe_boundary && link_sample == '0)
      else $error("link activity while disabled");
   a_sample_delay: assert property (up_cnt == 4'hf && !link_ctrl.hold_reset |-> link_sample[LINK_W-1 -: ADC_W] == $past(adc_sample, 5) && link_sample[LINK_W-ADC_W-1:1] == '0)
      else $error("sample not delayed intact");
endmodule
`default_nettype wire

// ==== tb/adl_link_regs_tb_top.sv ====
// self-checking bench for the dither and serial link control bank
`timescale 1ns/100ps
`default_nettype none
`include "adl_defines.svh"
module adl_link_regs_tb_top;
   import adl_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, calibration_enable;
   logic timestamp_receiver_enable, multiframe_boundary, mode_uses_64b66b;
   logic frame_tick, sysref_pulse, timestamp_in;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, ila_control_bits;
   logic [2:0] mode_e;
   logic [3:0] mode_f;
   logic [5:0] serial_output_mode;
   logic [10:0] frames_per_multiframe;
   logic [8:0] adc_sample;
   logic [11:0] link_sample;
   logic [7:0] v;
   adl_dither_t dither;
   adl_link_ctrl_t link_ctrl;
   int n_errors = 0;
   int n_checks = 0;
   logic [7:0] m [int];
   int regs [6] = '{`ADL_IDX_DITHER, `ADL_IDX_LSB_CTRL, `ADL_IDX_LINK_EN, `ADL_IDX_MODE,
      `ADL_IDX_KM1, `ADL_IDX_AUX};

   // hready is the single slave's own ready
   adl_link_regs adl_link_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dither(dither),
      .calibration_enable(calibration_enable),
      .timestamp_receiver_enable(timestamp_receiver_enable),
      .serial_output_mode(serial_output_mode), .mode_uses_64b66b(mode_uses_64b66b),
      .mode_e(mode_e), .mode_f(mode_f), .link_ctrl(link_ctrl),
      .frames_per_multiframe(frames_per_multiframe), .ila_control_bits(ila_control_bits),
      .frame_tick(frame_tick), .sysref_pulse(sysref_pulse),
      .multiframe_boundary(multiframe_boundary), .adc_sample(adc_sample),
      .timestamp_in(timestamp_in), .link_sample(link_sample));

   // 25 MHz bus clock
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task stop_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one single transfer; ready and read data are taken at the rising edge
   // no cycle limit here: only the watchdog may end a wait
   task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d,
      output logic [31:0] q);
      logic r;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {18'h0, idx, 2'b00};
      do begin
         @(posedge hclk);
         r = hreadyout;
      end while (!r);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= {24'h0, d};
      do begin
         @(posedge hclk);
         r = hreadyout;
         q = hrdata;
      end while (!r);
   endtask

   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d, rd);
      if (m.exists(idx)) m[idx] = d;
   endtask

   // unmapped places read as zero
   task automatic rc(input logic [11:0] idx);
      bus(1'b0, idx, 8'h00, rd);
      chk(rd, m.exists(idx) ? {24'h0, m[idx]} : 32'h0, "readback");
   endtask

   task automatic settle();
      repeat (2) @(posedge hclk);
      #1;
   endtask

   // random ticks and sysrefs against a counting model
   task automatic frm(input int k);
      int cnt;
      logic t, s, eb;
      @(posedge hclk);
      s = 1'b1;
      t = 1'b0;
      sysref_pulse <= 1'b1;
      for (int i = 0; i < 80; i++) begin
         @(posedge hclk);
         eb = s || (t && cnt == k - 1);
         cnt = s ? 0 : (t ? ((cnt == k - 1) ? 0 : cnt + 1) : cnt);
         t = 1'($urandom);
         s = ($urandom % 20) == 0;
         frame_tick <= t;
         sysref_pulse <= s;
         #1;
         chk(32'(multiframe_boundary), 32'(eb), "boundary");
      end
      frame_tick <= 1'b0;
      sysref_pulse <= 1'b0;
   endtask

   // samples come out four edges after they are taken
   task automatic samp(input logic ins);
      logic [11:0] q [$];
      for (int i = 0; i < 30; i++) begin
         @(posedge hclk);
         q.push_back({adc_sample, 2'b00, timestamp_in & ins});
         adc_sample <= 9'($urandom);
         timestamp_in <= 1'($urandom);
         #1;
         if (q.size() == 5) chk(32'(link_sample), 32'(q.pop_front()), "sample");
      end
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      mode_uses_64b66b = 1'b0;
      mode_e = 3'h1;
      mode_f = 4'h1;
      frame_tick = 1'b0;
      sysref_pulse = 1'b0;
      timestamp_in = 1'b0;
      adc_sample = 9'h000;
      m[`ADL_IDX_DITHER] = `ADL_RST_DITHER;
      m[`ADL_IDX_LSB_CTRL] = `ADL_RST_LSB_CTRL;
      m[`ADL_IDX_LINK_EN] = `ADL_RST_LINK_EN;
      m[`ADL_IDX_MODE] = `ADL_RST_MODE;
      m[`ADL_IDX_KM1] = `ADL_RST_KM1;
      m[`ADL_IDX_AUX] = `ADL_RST_AUX;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      void'($urandom(88040));
      settle();
      chk(32'(link_ctrl), 32'h1, "link after reset");
      chk(32'(frames_per_multiframe), 32'd32, "k after reset");
      foreach (regs[i]) rc(12'(regs[i]));
      for (int d = 0; d < 8; d++) begin
         wr(`ADL_IDX_DITHER, 8'(d));
         settle();
         chk(32'(dither), 32'(d), "dither");
      end
      wr(12'h150, 8'h5a);
      rc(12'h150);
      rc(`ADL_IDX_DITHER);
      wr(`ADL_IDX_LINK_EN, 8'h00);
      wr(`ADL_IDX_AUX, 8'h00);
      settle();
      chk(32'(link_ctrl), 32'h6, "link off");
      for (int i = 0; i < 3; i++) begin
         v = 8'($urandom);
         wr(`ADL_IDX_MODE, {2'b00, v[5:0]});
         wr(`ADL_IDX_KM1, v);
         rc(`ADL_IDX_MODE);
         rc(`ADL_IDX_KM1);
         settle();
         chk(32'(serial_output_mode), 32'(v[5:0]), "mode");
         chk(32'(frames_per_multiframe), 32'(v) + 32'd1, "k narrow");
         mode_uses_64b66b <= 1'b1;
         mode_e <= 3'($urandom);
         mode_f <= 4'($urandom);
         settle();
         chk(32'(frames_per_multiframe), 32'((256 * mode_e) / ((mode_f == 0) ? 1 : mode_f)), "k wide");
         mode_uses_64b66b <= 1'b0;
      end
      wr(`ADL_IDX_KM1, 8'h03);
      wr(`ADL_IDX_AUX, 8'h03);
      wr(`ADL_IDX_LSB_CTRL, 8'h01);
      wr(`ADL_IDX_LINK_EN, 8'h01);
      settle();
      chk(32'(link_ctrl), 32'h1, "link on");
      chk(32'({calibration_enable, timestamp_receiver_enable}), 32'h3, "aux");
      // status: link active, 8b/10b, k of four, counter still at zero
      bus(1'b0, `ADL_IDX_STATUS, 8'h00, rd);
      chk(rd, 32'h00040001, "status");
      frm(4);
      samp(1'b1);
      wr(`ADL_IDX_LSB_CTRL, 8'h00);
      samp(1'b0);
      wr(`ADL_IDX_LINK_EN, 8'h00);
      wr(`ADL_IDX_AUX, 8'h00);
      settle();
      for (int i = 0; i < 8; i++) begin
         @(posedge hclk);
         sysref_pulse <= ~sysref_pulse;
         #1;
         chk(32'({multiframe_boundary, link_sample}), 32'h0, "quiet off");
      end
      stop_test();
   end

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      stop_test();
   end
endmodule

bind adl_link_regs adl_link_monitor #(.ADC_W(ADC_W), .LINK_W(LINK_W), .E_W(E_W), .F_W(F_W))
   adl_link_monitor_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .link_ctrl(link_ctrl), .mode_uses_64b66b(mode_uses_64b66b), .mode_e(mode_e),
   .mode_f(mode_f), .frames_per_multiframe(frames_per_multiframe),
   .ila_control_bits(ila_control_bits), .sysref_pulse(sysref_pulse),
   .multiframe_boundary(multiframe_boundary), .adc_sample(adc_sample),
   .link_sample(link_sample));
`default_nettype wire
